/* include/wdt_pkg.sv */
// Purpose: Shared constants and types of the watchdog timeout reset block.
// Assumes: clk_i is the oscillator output clock; one osc cycle is one clk_i cycle.
// Notes: Register indexes are word indexes; byte address is four times the index.
package wdt_pkg;
    // Count chain shape
    localparam int PRE_W = 12;
    localparam int CNT_W = 6;
    localparam int CHAIN_W = PRE_W + CNT_W;
    localparam int SVC_LO = 4;
    // Last chain values before overflow: 262128 and 8176 cycles from zero
    localparam logic [17:0] LONG_LAST = 18'h3ffef;
    localparam logic [12:0] SHORT_LAST = 13'h1fef;
    // Cycle counts
    localparam int RST_PULSE_CYC = 32;
    localparam logic [5:0] PULSE_LAST = 6'(RST_PULSE_CYC - 1);
    localparam int POR_DLY_CYC = 4096;
    localparam logic [12:0] POR_LAST = 13'(POR_DLY_CYC - 1);
    // Register indexes and byte address width
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_CFG = 16'h001e;
    localparam logic [15:0] IDX_STAT = 16'h0001;
    localparam logic [15:0] IDX_COUNT = 16'h0002;
    localparam logic [15:0] IDX_SVC = 16'hffff;
    // Configuration fields and reset value
    localparam int CFG_DIS_BIT = 0;
    localparam int CFG_RATE_BIT = 1;
    localparam int CFG_STOP_BIT = 2;
    localparam logic [2:0] CFG_RST = 3'h0;
    // Status fields
    localparam int ST_CAUSE_BIT = 0;
    localparam int ST_DIS_BIT = 1;
    localparam int ST_STOP_BIT = 2;
    localparam int ST_PULSE_BIT = 3;

    typedef enum logic [1:0] {
        WDT_RUN = 2'b00,
        WDT_PULSE = 2'b01,
        WDT_STOPPED = 2'b10
    } wdt_state_t;
endpackage

/* include/wdt_chain_if.sv */
// Purpose: Control and count lines between the watchdog core and its count chain.
// Assumes: Both ends run on the same clock.
// Notes: Clears are levels sampled every cycle.
`timescale 1ns/1ps
interface wdt_chain_if;
    logic run;
    logic clr_all;
    logic clr_pre;
    logic clr_svc;
    logic [wdt_pkg::PRE_W-1:0] pre;
    logic [wdt_pkg::CNT_W-1:0] cnt;
    modport ctl (output run, output clr_all, output clr_pre, output clr_svc,
                 input pre, input cnt);
    modport chain (input run, input clr_all, input clr_pre, input clr_svc,
                   output pre, output cnt);
endinterface

/* hw/wdt_chain.sv */
// Purpose: Prescaler followed by a free-running counter that steps on prescaler carry.
// Assumes: Clear inputs are from logic on the same clock.
// Notes: Service clear keeps the low prescaler bits, so a period may be up to 15 short.
`timescale 1ns/1ps
module wdt_chain #(
    parameter int PRE_W = wdt_pkg::PRE_W,
    parameter int CNT_W = wdt_pkg::CNT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Chain port
    wdt_chain_if.chain ch
);
    logic [PRE_W-1:0] pre_q;
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || ch.clr_all || ch.clr_pre) begin
            pre_q <= '0;
        end else if (ch.clr_svc) begin
            pre_q <= {{(PRE_W-wdt_pkg::SVC_LO){1'b0}}, pre_q[wdt_pkg::SVC_LO-1:0]};
        end else if (ch.run) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || ch.clr_all || ch.clr_svc) begin
            cnt_q <= '0;
        end else if (ch.run && !ch.clr_pre && (&pre_q)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign ch.pre = pre_q;
    assign ch.cnt = cnt_q;
endmodule

/* hw/wdt_top.sv */
// Purpose: Watchdog that resets the system when software stops servicing it.
// Assumes: APB slave, one wait-free access phase; pins for test voltage are asynchronous.
// Notes: The system reset request is decoded from the state register and held for the whole reset pulse.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module wdt_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [wdt_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // System events
    input wire logic por_i,
    input wire logic int_rst_i,
    input wire logic vec_fetch_i,
    input wire logic [7:0] vec_low_i,
    input wire logic stop_exec_i,
    input wire logic wake_i,
    input wire logic wait_mode_i,
    input wire logic mon_entry_i,
    input wire logic mon_blank_i,
    input wire logic break_i,
    // Test voltage detectors on the pins
    input wire logic irq_vtst_i,
    input wire logic rst_vtst_i,
    // Reset and stop outputs
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    output logic sys_rst_req_o,
    output logic illop_rst_o,
    output logic stopped_o
);
    wdt_chain_if ch ();
    wdt_chain #(
        .PRE_W(wdt_pkg::PRE_W),
        .CNT_W(wdt_pkg::CNT_W)
    ) u_chain (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ch(ch)
    );

    wdt_pkg::wdt_state_t state_q;
    logic [2:0] cfg_q;
    logic cfg_lock_q;
    logic cause_q;
    logic [5:0] pulse_cnt_q;
    logic [12:0] por_cnt_q;
    logic por_busy_q;
    logic por_clr_q;
    logic mon_hold_q;
    logic blank_dis_q;
    logic illop_q;
    logic [1:0] vt_s1_q;
    logic [1:0] vt_s2_q;
    logic [1:0] vt_s3_q;
    logic [1:0] vt_q;
    logic [31:0] rdata_q;
    logic err_q;

    // APB decode
    logic setup;
    logic access;
    logic [15:0] idx;
    logic aligned;
    logic hit;
    logic svc_wr;
    logic cfg_wr;
    logic stat_rd;
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign idx = paddr_i[wdt_pkg::ADDR_W-1:2];
    assign aligned = (paddr_i[1:0] == 2'b00);
    assign hit = aligned && (idx == wdt_pkg::IDX_CFG || idx == wdt_pkg::IDX_STAT ||
                             idx == wdt_pkg::IDX_COUNT || idx == wdt_pkg::IDX_SVC);
    assign svc_wr = access && pwrite_i && hit && (idx == wdt_pkg::IDX_SVC);
    assign cfg_wr = access && pwrite_i && hit && (idx == wdt_pkg::IDX_CFG);
    assign stat_rd = access && !pwrite_i && hit && (idx == wdt_pkg::IDX_STAT);
    assign pready_o = 1'b1;

    // Test voltage levels: three flops, a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            vt_s1_q <= 2'h0;
            vt_s2_q <= 2'h0;
            vt_s3_q <= 2'h0;
            vt_q <= 2'h0;
        end else begin
            vt_s1_q <= {rst_vtst_i, irq_vtst_i};
            vt_s2_q <= vt_s1_q;
            vt_s3_q <= vt_s2_q;
            for (int i = 0; i < 2; i++) begin
                if (vt_s2_q[i] == vt_s3_q[i]) begin
                    vt_q[i] <= vt_s3_q[i];
                end
            end
        end
    end

    // Disable sources
    logic irq_vt;
    logic rst_vt;
    logic eff_dis;
    assign irq_vt = vt_q[0];
    assign rst_vt = vt_q[1];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mon_hold_q <= 1'b0;
        end else if (mon_entry_i && irq_vt) begin
            mon_hold_q <= 1'b1;
        end else if (!irq_vt && !rst_vt) begin
            mon_hold_q <= 1'b0;
        end
    end

    // Only power-up lifts the blank-vector hold; ordinary resets leave it
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            blank_dis_q <= 1'b0;
        end else if (mon_entry_i && mon_blank_i && !irq_vt) begin
            blank_dis_q <= 1'b1;
        end
    end

    assign eff_dis = cfg_q[wdt_pkg::CFG_DIS_BIT] || mon_hold_q || blank_dis_q ||
                     (break_i && rst_vt);

    // Configuration latches: written once after each reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_q <= wdt_pkg::CFG_RST;
            cfg_lock_q <= 1'b0;
        end else if (cfg_wr && !cfg_lock_q && pstrb_i[0]) begin
            cfg_q <= pwdata_i[2:0];
            cfg_lock_q <= 1'b1;
        end
    end

    // Power-up delay before the prescaler clear
    // Power-up outranks the system reset that comes with it, or the delay would never start
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            por_cnt_q <= 13'h0;
            por_busy_q <= 1'b1;
            por_clr_q <= 1'b0;
        end else if (sys_rst_i) begin
            por_cnt_q <= 13'h0;
            por_busy_q <= 1'b0;
            por_clr_q <= 1'b0;
        end else if (por_busy_q) begin
            por_cnt_q <= por_cnt_q + 13'h1;
            por_clr_q <= (por_cnt_q == wdt_pkg::POR_LAST);
            por_busy_q <= (por_cnt_q != wdt_pkg::POR_LAST);
        end else begin
            por_clr_q <= 1'b0;
        end
    end

    // Overflow decode on the chain value
    logic [17:0] chain;
    logic running;
    logic fire;
    assign chain = {ch.cnt, ch.pre};
    assign running = (state_q == wdt_pkg::WDT_RUN) && !eff_dis;
    assign fire = running && !int_rst_i &&
                  (cfg_q[wdt_pkg::CFG_RATE_BIT] ? (chain[12:0] == wdt_pkg::SHORT_LAST)
                                               : (chain == wdt_pkg::LONG_LAST));

    // Chain control; wait mode is not a term here, so the chain keeps counting in it
    assign ch.run = running;
    assign ch.clr_all = int_rst_i || eff_dis || (state_q == wdt_pkg::WDT_PULSE);
    assign ch.clr_pre = por_clr_q || vec_fetch_i ||
                        (stop_exec_i && cfg_q[wdt_pkg::CFG_STOP_BIT]);
    assign ch.clr_svc = svc_wr;

    // Main sequencer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= wdt_pkg::WDT_RUN;
            pulse_cnt_q <= 6'h0;
        end else begin
            unique case (state_q)
                wdt_pkg::WDT_RUN: begin
                    pulse_cnt_q <= 6'h0;
                    if (fire) begin
                        state_q <= wdt_pkg::WDT_PULSE;
                    end else if (stop_exec_i && cfg_q[wdt_pkg::CFG_STOP_BIT]) begin
                        state_q <= wdt_pkg::WDT_STOPPED;
                    end
                end
                wdt_pkg::WDT_PULSE: begin
                    pulse_cnt_q <= pulse_cnt_q + 6'h1;
                    if (pulse_cnt_q == wdt_pkg::PULSE_LAST) begin
                        state_q <= wdt_pkg::WDT_RUN;
                    end
                end
                wdt_pkg::WDT_STOPPED: begin
                    if (wake_i || int_rst_i) begin
                        state_q <= wdt_pkg::WDT_RUN;
                    end
                end
                default: begin
                    state_q <= wdt_pkg::WDT_RUN;
                end
            endcase
        end
    end

    // Reset pin driven low and request held for the pulse; no interrupt output exists
    assign sys_rst_req_o = (state_q == wdt_pkg::WDT_PULSE);
    assign rst_pin_oe_o = (state_q == wdt_pkg::WDT_PULSE);
    assign rst_pin_o = 1'b0;
    assign stopped_o = (state_q == wdt_pkg::WDT_STOPPED);

    // Illegal-opcode reset when stop is not allowed
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            illop_q <= 1'b0;
        end else begin
            illop_q <= stop_exec_i && !cfg_q[wdt_pkg::CFG_STOP_BIT] &&
                       (state_q == wdt_pkg::WDT_RUN);
        end
    end
    assign illop_rst_o = illop_q;

    // Cause flag: a new timeout wins over the clear-on-read
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cause_q <= 1'b0;
        end else if (fire) begin
            cause_q <= 1'b1;
        end else if (stat_rd) begin
            cause_q <= 1'b0;
        end
    end

    // Read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= 32'h0;
            err_q <= 1'b0;
        end else if (setup) begin
            err_q <= !hit;
            rdata_q <= 32'h0;
            if (hit && !pwrite_i) begin
                unique case (idx)
                    wdt_pkg::IDX_CFG: rdata_q <= {29'h0, cfg_q};
                    wdt_pkg::IDX_STAT: begin
                        rdata_q <= {28'h0, (state_q == wdt_pkg::WDT_PULSE),
                                    (state_q == wdt_pkg::WDT_STOPPED), eff_dis, cause_q};
                    end
                    wdt_pkg::IDX_COUNT: rdata_q <= {14'h0, chain};
                    wdt_pkg::IDX_SVC: rdata_q <= {24'h0, vec_low_i};
                    default: rdata_q <= 32'h0;
                endcase
            end
        end
    end
    assign prdata_o = rdata_q;
    assign pslverr_o = err_q;

    // Checks
    a_pulse_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(sys_rst_req_o) |-> ##31 sys_rst_req_o ##1 !sys_rst_req_o)
        else $error("reset pulse is not 32 cycles");
    a_cause_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(sys_rst_req_o) |-> cause_q && rst_pin_oe_o && !rst_pin_o)
        else $error("timeout without cause flag or pin drive");
    a_short_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (running && !int_rst_i && cfg_q[1] && chain[12:0] == 13'h1fef) |=> sys_rst_req_o)
        else $error("short timeout missed");
    a_long_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (running && !cfg_q[1] && chain[12:0] == 13'h1fef && ch.cnt[5:1] != 5'h1f)
        |=> !sys_rst_req_o)
        else $error("long rate fired early");
    a_dis_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        eff_dis |=> !$rose(sys_rst_req_o))
        else $error("reset while disabled");
    a_svc_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        svc_wr |=> (ch.cnt == 6'h0) && (ch.pre[11:4] == 8'h0))
        else $error("service write did not clear chain");
    a_stop_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (stopped_o && $past(stopped_o) && !$past(ch.clr_pre || ch.clr_all || ch.clr_svc))
        |-> $stable(chain))
        else $error("chain moved in stop mode");
    a_illop_rst: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (stop_exec_i && !cfg_q[2] && state_q == wdt_pkg::WDT_RUN) |=> illop_rst_o && !stopped_o)
        else $error("disabled stop did not give illegal-opcode reset");
    a_por_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (por_busy_q && !por_i && por_cnt_q == 13'hfff) |=> ##1 (ch.pre == 12'h0))
        else $error("prescaler not cleared after power-up delay");
    a_vec_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (setup && !pwrite_i && aligned && idx == 16'hffff) |=> prdata_o == {24'h0, $past(vec_low_i)})
        else $error("service read did not return vector byte");
    a_mon_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (mon_entry_i && irq_vt) |=> (eff_dis && !sys_rst_req_o))
        else $error("monitor entry with test voltage left watchdog on");
    a_wait_run: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (wait_mode_i && ch.run && !ch.clr_all && !ch.clr_pre && !ch.clr_svc)
        |=> !$stable(chain))
        else $error("chain stalled in wait mode");
    a_vec_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        vec_fetch_i |=> (ch.pre == 12'h0))
        else $error("vector fetch did not clear prescaler");
    a_int_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        int_rst_i |=> (chain == 18'h0))
        else $error("internal reset did not clear chain");
endmodule

/* dv/tb_wdt_top.sv */
// Purpose: Self-checking bench for the watchdog timeout reset block.
// Assumes: One clock; APB answers with no wait states; read notes queued in order.
// Notes: The long period only gets a no-early-fire check, since a full run is too slow.
`timescale 1ns/1ps
module tb_wdt_top;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} wdt_note_t;
    localparam logic [17:0] A_CFG = {wdt_pkg::IDX_CFG, 2'b00};
    localparam logic [17:0] A_STAT = {wdt_pkg::IDX_STAT, 2'b00};
    localparam logic [17:0] A_CNT = {wdt_pkg::IDX_COUNT, 2'b00};
    localparam logic [17:0] A_SVC = {wdt_pkg::IDX_SVC, 2'b00};
    localparam logic [31:0] C_DIS = 32'h1 << wdt_pkg::CFG_DIS_BIT;
    localparam logic [31:0] C_RATE = 32'h1 << wdt_pkg::CFG_RATE_BIT;
    localparam logic [31:0] C_STOP = 32'h1 << wdt_pkg::CFG_STOP_BIT;
    localparam logic [31:0] S_CAUSE = 32'h1 << wdt_pkg::ST_CAUSE_BIT;
    localparam logic [31:0] S_DIS = 32'h1 << wdt_pkg::ST_DIS_BIT;
    localparam logic [31:0] S_STOP = 32'h1 << wdt_pkg::ST_STOP_BIT;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, por_i = 1'b1, int_rst_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [17:0] paddr_i = 18'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0] pstrb_i = 4'h0;
    logic vec_fetch_i = 1'b0, stop_exec_i = 1'b0, wake_i = 1'b0, wait_mode_i = 1'b0;
    logic mon_entry_i = 1'b0, mon_blank_i = 1'b0, break_i = 1'b0;
    logic irq_vtst_i = 1'b0, rst_vtst_i = 1'b0;
    logic [7:0] vec_low_i;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, rst_pin_o, rst_pin_oe_o, sys_rst_req_o, illop_rst_o, stopped_o;
    wdt_note_t q[$];
    int errors = 0;
    int check_count = 0;
    int seed = 32'h3172;

    wdt_top wdt_top_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .por_i(por_i),
        .int_rst_i(int_rst_i), .vec_fetch_i(vec_fetch_i), .vec_low_i(vec_low_i),
        .stop_exec_i(stop_exec_i), .wake_i(wake_i), .wait_mode_i(wait_mode_i),
        .mon_entry_i(mon_entry_i), .mon_blank_i(mon_blank_i), .break_i(break_i),
        .irq_vtst_i(irq_vtst_i), .rst_vtst_i(rst_vtst_i), .rst_pin_o(rst_pin_o),
        .rst_pin_oe_o(rst_pin_oe_o), .sys_rst_req_o(sys_rst_req_o),
        .illop_rst_o(illop_rst_o), .stopped_o(stopped_o)
    );

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Every access leaves a note; writes carry an empty data mask
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic [31:0] m, input logic ee);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= 4'($random(seed)) | 4'h1;
        q.push_back('{ed, m, ee});
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    always @(posedge clk_i) begin
        wdt_note_t nt;
        if (psel_i && penable_i && pready_o === 1'b1 && q.size() != 0) begin
            nt = q.pop_front();
            chk(prdata_o & nt.m, nt.d & nt.m);
            chk(32'(pslverr_o), 32'(nt.e));
        end
    end

    task automatic do_reset();
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
    endtask

    task automatic zero_chain();
        @(posedge clk_i);
        int_rst_i <= 1'b1;
        @(posedge clk_i);
        int_rst_i <= 1'b0;
    endtask

    // Cycles until the reset request, then its width and the pin drive
    task automatic time_out(input int lo, input int hi);
        int n;
        int w;
        n = 0;
        w = 0;
        while (sys_rst_req_o !== 1'b1 && n < 20000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
        while (sys_rst_req_o === 1'b1 && w < 100) begin
            chk({30'h0, rst_pin_oe_o, rst_pin_o}, 32'h2);
            @(posedge clk_i);
            #1;
            w++;
        end
        chk(32'(w), 32'(wdt_pkg::RST_PULSE_CYC));
    endtask

    task automatic quiet(input int n);
        int f;
        f = 0;
        repeat (n) begin
            @(posedge clk_i);
            if (sys_rst_req_o !== 1'b0) f++;
        end
        chk(32'(f), 32'h0);
    endtask

    initial begin
        fork
            begin
                #(25 * 70000);
                errors++;
                wrap_up();
            end
        join_none
        vec_low_i <= 8'($random(seed));
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        por_i <= 1'b0;
        apb(1'b1, A_CFG, C_RATE, 0, 0, 1'b0);
        apb(1'b0, A_STAT, 0, 32'h0, 32'hf, 1'b0);
        apb(1'b0, A_SVC, 0, {24'h0, vec_low_i}, 32'hffffffff, 1'b0);
        apb(1'b0, 18'h00100, 0, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b0, 18'h00005, 0, 32'h0, 32'hffffffff, 1'b1);
        @(posedge clk_i);
        stop_exec_i <= 1'b1;
        @(posedge clk_i);
        stop_exec_i <= 1'b0;
        #1 chk({30'h0, illop_rst_o, stopped_o}, 32'h2);
        @(posedge clk_i);
        #1 chk(32'(illop_rst_o), 32'h0);
        irq_vtst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        mon_entry_i <= 1'b1;
        @(posedge clk_i);
        mon_entry_i <= 1'b0;
        apb(1'b0, A_STAT, 0, S_DIS, S_DIS, 1'b0);
        irq_vtst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        apb(1'b0, A_STAT, 0, 32'h0, S_DIS, 1'b0);
        break_i <= 1'b1;
        rst_vtst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        apb(1'b0, A_STAT, 0, S_DIS, S_DIS, 1'b0);
        break_i <= 1'b0;
        apb(1'b0, A_STAT, 0, 32'h0, S_DIS, 1'b0);
        rst_vtst_i <= 1'b0;
        // Let the power-up prescaler clear pass so it cannot skew the counts below
        repeat (4200) @(posedge clk_i);
        int_rst_i <= 1'b1;
        apb(1'b0, A_CNT, 0, 32'h0, 32'hffffffff, 1'b0);
        int_rst_i <= 1'b0;
        repeat (4100) @(posedge clk_i);
        apb(1'b0, A_CNT, 0, 32'h1000, 32'hfffff000, 1'b0);
        vec_fetch_i <= 1'b1;
        @(posedge clk_i);
        vec_fetch_i <= 1'b0;
        apb(1'b0, A_CNT, 0, 32'h0, 32'h00000ff8, 1'b0);
        wait_mode_i <= 1'b1;
        zero_chain();
        time_out(8176, 8177);
        wait_mode_i <= 1'b0;
        apb(1'b0, A_STAT, 0, S_CAUSE, S_CAUSE, 1'b0);
        apb(1'b0, A_STAT, 0, 32'h0, S_CAUSE, 1'b0);
        zero_chain();
        repeat (6000) @(posedge clk_i);
        apb(1'b1, A_SVC, $random(seed), 0, 0, 1'b0);
        apb(1'b0, A_CNT, 0, 32'h0, 32'hffffffe0, 1'b0);
        time_out(8155, 8177);
        do_reset();
        apb(1'b1, A_CFG, C_DIS | C_RATE, 0, 0, 1'b0);
        apb(1'b1, A_CFG, 32'h0, 0, 0, 1'b0);
        apb(1'b0, A_STAT, 0, S_DIS, S_DIS, 1'b0);
        quiet(9000);
        apb(1'b0, A_CNT, 0, 32'h0, 32'hffffffff, 1'b0);
        do_reset();
        apb(1'b1, A_CFG, C_STOP | C_RATE, 0, 0, 1'b0);
        repeat (100) @(posedge clk_i);
        apb(1'b1, A_SVC, 32'h0, 0, 0, 1'b0);
        stop_exec_i <= 1'b1;
        @(posedge clk_i);
        stop_exec_i <= 1'b0;
        #1 chk({30'h0, illop_rst_o, stopped_o}, 32'h1);
        repeat (50) @(posedge clk_i);
        apb(1'b0, A_CNT, 0, 32'h0, 32'h00000fff, 1'b0);
        apb(1'b0, A_STAT, 0, S_STOP, S_STOP, 1'b0);
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk(32'(stopped_o), 32'h0);
        do_reset();
        zero_chain();
        quiet(8300);
        apb(1'b0, A_CNT, 0, 32'h2000, 32'hffffe000, 1'b0);
        mon_blank_i <= 1'b1;
        mon_entry_i <= 1'b1;
        @(posedge clk_i);
        mon_blank_i <= 1'b0;
        mon_entry_i <= 1'b0;
        do_reset();
        apb(1'b0, A_STAT, 0, S_DIS, S_DIS, 1'b0);
        por_i <= 1'b1;
        @(posedge clk_i);
        por_i <= 1'b0;
        apb(1'b0, A_STAT, 0, 32'h0, S_DIS, 1'b0);
        wrap_up();
    end
endmodule
